// file: core/rfd_decoder.sv
// register file address decoder: ram, control region, unpopulated space
`timescale 1ns/100ps
`include "rfd_consts.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01 - decode full 4096-byte register file space
// R02 - top 256 bytes F00-FFF are control
// R03 - reserved control reads return undefined data
// R04 - core should not write reserved control
// R05 - ram mapped from address 000 upward
// R06 - ram size parameter, 2KB to 4KB
// R07 - unpopulated reads return undefined data
// R08 - unpopulated writes are discarded entirely
// R09 - source reads, destination writes
// R10 - control decode overrides ram in F00-FFF
module rfd_decoder #(
   parameter int RAM_BYTES = `RFD_RAM_DEF
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_n_in,
   input  wire rfd_pkg::rfd_req_t      req_in,
   input  wire logic [`RFD_DATA_W-1:0] ctrl_rdata_in,
   input  wire logic                   ctrl_hit_in,
   output logic                        ctrl_rd_out,
   output logic                        ctrl_wr_out,
   output logic [`RFD_ADDR_W-1:0]      ctrl_addr_out,
   output logic [`RFD_DATA_W-1:0]      ctrl_wdata_out,
   output logic [`RFD_DATA_W-1:0]      rdata_out,
   output logic                        rvalid_out
);
   ////////////////////////////////////////////////////////////////////////
   // region decode; purely combinational so the control strobes leave in
   // the cycle the core asks, at the cost of a long address compare path
   localparam logic [`RFD_ADDR_W:0] RAM_LIMIT = (`RFD_ADDR_W+1)'(RAM_BYTES);
   rfd_pkg::rfd_region_t region;
   rfd_pkg::rfd_region_t region_q;
   logic                 ram_we;
   logic [`RFD_DATA_W-1:0] ram_rdata;

   // control region checked first so a 4KB ram never answers there
   always_comb begin
      if (req_in.addr >= `RFD_CTRL_BASE) begin // R02 R10
         region = rfd_pkg::RFD_REG_CTRL;
      end else if ({1'b0, req_in.addr} < RAM_LIMIT) begin // R05 R06
         region = rfd_pkg::RFD_REG_RAM;
      end else begin
         region = rfd_pkg::RFD_REG_NONE; // R01
      end
   end

   // writes outside ram reach no storage
   assign ram_we = req_in.wr && (region == rfd_pkg::RFD_REG_RAM); // R08 R09

   // ram storage sits in its own module so its size follows the parameter;
   // read data comes back registered, one cycle after the read is taken
   rfd_ram #(.RAM_BYTES(RAM_BYTES)) u_ram (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .we_in      (ram_we),
      .addr_in    (req_in.addr),
      .wdata_in   (req_in.wdata),
      .rdata_out  (ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // control region strobes; reserved writes pass on, outcome is the core's
   // concern since the peripheral decides what an unassigned slot does
   assign ctrl_rd_out    = req_in.rd && (region == rfd_pkg::RFD_REG_CTRL);
   assign ctrl_wr_out    = req_in.wr && (region == rfd_pkg::RFD_REG_CTRL);
   assign ctrl_addr_out  = req_in.addr;
   assign ctrl_wdata_out = req_in.wdata;

   ////////////////////////////////////////////////////////////////////////
   // remember the region of a read for the answer cycle
   // rvalid follows every read, whatever region it lands in
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         region_q   <= rfd_pkg::RFD_REG_NONE;
         rvalid_out <= 1'b0;
      end else begin
         region_q   <= region;
         rvalid_out <= req_in.rd; // R09
      end
   end

   logic ctrl_ok_q;
   logic [`RFD_DATA_W-1:0] ctrl_data_q;

   // control data captured so the read data output comes from flip-flops
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_data_q <= `RFD_FILL_DATA;
         ctrl_ok_q   <= 1'b0;
      end else begin
         ctrl_data_q <= ctrl_rdata_in;
         ctrl_ok_q   <= ctrl_hit_in;
      end
   end

   // undefined answers are a fixed fill value, cheaper than holding old data
   always_comb begin
      case (region_q)
         rfd_pkg::RFD_REG_RAM: begin
            rdata_out = ram_rdata;
         end
         rfd_pkg::RFD_REG_CTRL: begin
            rdata_out = ctrl_ok_q ? ctrl_data_q : `RFD_FILL_DATA; // R03
         end
         default: begin
            rdata_out = `RFD_FILL_DATA; // R07
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks; every property is quiet while reset is low unless it says
   // otherwise, and all of them run on the one clock
   ////////////////////////////////////////////////////////////////////////
   // sequences for the one-cycle ram write and for the behaviours that take more than one step
   // a ram write inside the fitted size and below the control region
   sequence ram_write_s;
      req_in.wr && {1'b0, req_in.addr} < RAM_LIMIT
         && req_in.addr < `RFD_CTRL_BASE;
   endsequence

   // a write into ram, the first step of a read-after-write
   sequence ram_wr_s;
      req_in.wr && (region == rfd_pkg::RFD_REG_RAM);
   endsequence

   // the very next cycle reads back the same byte
   sequence ram_rd_same_s;
      req_in.rd && !req_in.wr && (req_in.addr == $past(req_in.addr));
   endsequence

   // a populated control slot is read this cycle
   sequence ctrl_hit_s;
      ctrl_rd_out && ctrl_hit_in;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // properties

   ctrl_no_ram_a : assert property (@(posedge ref_clk_in) // R10
      disable iff (!rst_n_in) req_in.addr >= `RFD_CTRL_BASE |-> !ram_we)
      else $error("ram written inside control region");

   ctrl_strobe_a : assert property (@(posedge ref_clk_in) // R02
      disable iff (!rst_n_in)
      (req_in.wr && req_in.addr >= `RFD_CTRL_BASE) |-> ctrl_wr_out)
      else $error("control write not strobed");

   none_discard_a : assert property (@(posedge ref_clk_in) // R08
      disable iff (!rst_n_in)
      (region == rfd_pkg::RFD_REG_NONE) |-> !ram_we && !ctrl_wr_out)
      else $error("unpopulated write reached storage");

   ram_write_a : assert property (@(posedge ref_clk_in) // R05
      disable iff (!rst_n_in) ram_write_s |-> ram_we)
      else $error("ram write dropped");

   read_answer_a : assert property (@(posedge ref_clk_in) // R09
      disable iff (!rst_n_in) req_in.rd |=> rvalid_out)
      else $error("read not answered next cycle");

   none_fill_a : assert property (@(posedge ref_clk_in) // R07
      disable iff (!rst_n_in)
      (req_in.rd && region == rfd_pkg::RFD_REG_NONE)
      |=> rdata_out == `RFD_FILL_DATA)
      else $error("unpopulated read not fill value");

   rsvd_fill_a : assert property (@(posedge ref_clk_in) // R03
      disable iff (!rst_n_in)
      (ctrl_rd_out && !ctrl_hit_in) |=> rdata_out == `RFD_FILL_DATA)
      else $error("reserved read not fill value");

   size_range_a : assert property (@(posedge ref_clk_in) // R06
      disable iff (!rst_n_in)
      RAM_BYTES >= `RFD_RAM_MIN && RAM_BYTES <= `RFD_RAM_MAX)
      else $error("ram size out of range");

   space_full_a : assert property (@(posedge ref_clk_in) // R01
      disable iff (!rst_n_in)
      req_in.wr |-> $onehot({ram_we, ctrl_wr_out,
                              region == rfd_pkg::RFD_REG_NONE}))
      else $error("write decoded to no region or to several");

   ram_forward_a : assert property (@(posedge ref_clk_in) // R05
      disable iff (!rst_n_in)
      ram_wr_s ##1 ram_rd_same_s |=> rdata_out == $past(req_in.wdata, 2))
      else $error("ram read after write returned stale data");

   ctrl_rd_strobe_a : assert property (@(posedge ref_clk_in) // R02
      disable iff (!rst_n_in)
      (req_in.rd && req_in.addr >= `RFD_CTRL_BASE) |-> ctrl_rd_out)
      else $error("control read not strobed");

   ctrl_quiet_a : assert property (@(posedge ref_clk_in) // R02
      disable iff (!rst_n_in)
      req_in.addr < `RFD_CTRL_BASE |-> !ctrl_rd_out && !ctrl_wr_out)
      else $error("control strobe outside control region");

   ram_bound_a : assert property (@(posedge ref_clk_in) // R06
      disable iff (!rst_n_in)
      ({1'b0, req_in.addr} >= RAM_LIMIT) |-> !ram_we)
      else $error("ram written above fitted size");

   ctrl_data_a : assert property (@(posedge ref_clk_in) // R09
      disable iff (!rst_n_in)
      ctrl_hit_s |=> rdata_out == $past(ctrl_rdata_in))
      else $error("control read data lost");

   none_quiet_a : assert property (@(posedge ref_clk_in) // R07
      disable iff (!rst_n_in)
      (region == rfd_pkg::RFD_REG_NONE) |-> !ctrl_rd_out)
      else $error("unpopulated read reached control region");

   read_pulse_a : assert property (@(posedge ref_clk_in) // R09
      disable iff (!rst_n_in) !req_in.rd |=> !rvalid_out)
      else $error("read answer without a read");

   // checked from the second reset edge, once the reset has taken hold
   reset_idle_a : assert property (@(posedge ref_clk_in) // R09
      !rst_n_in ##1 !rst_n_in |-> !rvalid_out && rdata_out == `RFD_FILL_DATA)
      else $error("outputs not idle during reset");
endmodule : rfd_decoder

// file: core/rfd_consts.svh
// constants for the register file address decoder
`ifndef RFD_CONSTS_SVH
`define RFD_CONSTS_SVH
`define RFD_ADDR_W      12
`define RFD_DATA_W      8
`define RFD_SPACE_BYTES 4096
`define RFD_CTRL_BASE   12'hF00
`define RFD_CTRL_TOP    12'hFFF
`define RFD_CTRL_BYTES  256
`define RFD_RAM_BASE    12'h000
`define RFD_RAM_MIN     2048
`define RFD_RAM_MAX     4096
`define RFD_RAM_DEF     4096
`define RFD_FILL_DATA   8'h00
`endif

// file: core/rfd_pkg.sv
// types for the register file address decoder
`include "rfd_consts.svh"
package rfd_pkg;
   typedef enum logic [1:0] {
      RFD_REG_RAM,
      RFD_REG_CTRL,
      RFD_REG_NONE
   } rfd_region_t;

   typedef struct packed {
      logic                      rd;
      logic                      wr;
      logic [`RFD_ADDR_W-1:0]    addr;
      logic [`RFD_DATA_W-1:0]    wdata;
   } rfd_req_t;
endpackage : rfd_pkg

// file: core/rfd_ram.sv
// flip-flop storage for the general-purpose register region
`timescale 1ns/100ps
`include "rfd_consts.svh"
module rfd_ram #(
   parameter int RAM_BYTES = `RFD_RAM_DEF
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   we_in,
   input  wire logic [`RFD_ADDR_W-1:0] addr_in,
   input  wire logic [`RFD_DATA_W-1:0] wdata_in,
   output logic      [`RFD_DATA_W-1:0] rdata_out
);
   localparam int IDX_W = $clog2(RAM_BYTES);
   logic [`RFD_DATA_W-1:0] mem_q [RAM_BYTES];
   logic [IDX_W-1:0]       idx;

   // the index drops the address bits above the fitted size; the decoder
   // only raises the write enable below it, so no write ever aliases
   assign idx = addr_in[IDX_W-1:0];

   // storage is not reset; software must initialise its own variables
   always_ff @(posedge ref_clk_in) begin
      if (we_in) begin
         mem_q[idx] <= wdata_in;
      end
   end

   // registered read data, one cycle after the request
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= `RFD_FILL_DATA;
      end else begin
         rdata_out <= mem_q[idx];
      end
   end
endmodule : rfd_ram

// file: dv/rfd_ctrl_model.sv
// behavioural control-register peripherals facing the decoder
`timescale 1ns/100ps
`include "rfd_consts.svh"
module rfd_ctrl_model (
   input  wire logic [`RFD_ADDR_W-1:0] addr_in,
   output logic      [`RFD_DATA_W-1:0] rdata_out,
   output logic                        hit_out
);
   // lower half of the control region is populated, upper half reserved
   assign hit_out = ~addr_in[7];
   // a reserved slot drives a scrambled byte so that a leak shows up
   assign rdata_out = hit_out ? (addr_in[7:0] ^ 8'h5A) : ~addr_in[7:0];
endmodule : rfd_ctrl_model

// file: dv/tb.sv
// self-checking bench for the register file address decoder
`timescale 1ns/100ps
`include "rfd_consts.svh"
module tb;
   logic                   ref_clk_in = 1'b0;
   logic                   rst_n_in   = 1'b0;
   rfd_pkg::rfd_req_t      req        = '0;
   logic [`RFD_DATA_W-1:0] c_rdata, c_wdata, rdata;
   logic [`RFD_ADDR_W-1:0] c_addr;
   logic                   c_hit, c_rd, c_wr, rvalid;
   int                     miscompares = 0;
   int                     checks      = 0;
   always #2 ref_clk_in = ~ref_clk_in;
   // small ram so that 800-EFF is unpopulated space
   rfd_decoder #(.RAM_BYTES(2048)) rfd_decoder_i (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req),
      .ctrl_rdata_in(c_rdata), .ctrl_hit_in(c_hit), .ctrl_rd_out(c_rd),
      .ctrl_wr_out(c_wr), .ctrl_addr_out(c_addr), .ctrl_wdata_out(c_wdata),
      .rdata_out(rdata), .rvalid_out(rvalid));
   rfd_ctrl_model rfd_ctrl_model_i (
      .addr_in(c_addr), .rdata_out(c_rdata), .hit_out(c_hit));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // one write cycle; the control strobe must follow the region at once
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_in) req <= '{rd:1'b0, wr:1'b1, addr:a, wdata:d};
      #1 chk("ctrl_wr", {7'h00, c_wr}, {7'h00, a >= 12'hF00});
      chk("ctrl_wdata", c_wdata, d);
      chk("ctrl_addr", c_addr[11:4], a[11:4]);
      @(posedge ref_clk_in) req <= '0;
   endtask : wr
   // one read cycle; rvalid stands only in the cycle after it is taken
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk_in) req <= '{rd:1'b1, wr:1'b0, addr:a, wdata:8'h00};
      #1 chk("ctrl_rd", {7'h00, c_rd}, {7'h00, a >= 12'hF00});
      @(posedge ref_clk_in) req <= '0;
      #1 chk("rvalid", {7'h00, rvalid}, 8'h01);
      chk("rdata", rdata, e);
      @(posedge ref_clk_in);
      #1 chk("rvalid_end", {7'h00, rvalid}, 8'h00);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   task automatic t_ram;
      wr(12'h000, 8'h11);
      wr(12'h7FF, 8'h22);
      rd(12'h000, 8'h11);
      rd(12'h7FF, 8'h22);
      $display("test ram done");
   endtask : t_ram
   // writes above the fitted ram must not alias into it
   task automatic t_unpop;
      wr(12'h800, 8'hAA);
      wr(12'hEFF, 8'hBB);
      rd(12'h800, 8'h00);
      rd(12'hEFF, 8'h00);
      rd(12'h000, 8'h11);
      rd(12'h7FF, 8'h22);
      $display("test unpopulated done");
   endtask : t_unpop
   // a write and a read of one ram byte in consecutive cycles
   task automatic t_b2b;
      @(posedge ref_clk_in)
         req <= '{rd:1'b0, wr:1'b1, addr:12'h123, wdata:8'h5C};
      @(posedge ref_clk_in)
         req <= '{rd:1'b1, wr:1'b0, addr:12'h123, wdata:8'h00};
      @(posedge ref_clk_in) req <= '0;
      #1 chk("b2b_rdata", rdata, 8'h5C);
      chk("b2b_rvalid", {7'h00, rvalid}, 8'h01);
      $display("test back to back done");
   endtask : t_b2b
   // only assigned control slots are written by the core
   task automatic t_ctrl;
      rd(12'hF10, 8'h4A);
      rd(12'hF00, 8'h5A);
      rd(12'hFFF, 8'h00);
      wr(12'hF20, 8'h33);
      rd(12'hF7F, 8'h25);
      $display("test control done");
   endtask : t_ctrl
   task automatic results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////
   // main sequence after ten cycles of reset
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1 chk("rst_rvalid", {7'h00, rvalid}, 8'h00);
      chk("rst_rdata", rdata, 8'h00);
      t_ram;
      t_unpop;
      t_b2b;
      t_ctrl;
      results;
   end
   // the tests need well under a thousand cycles
   initial begin
      #20000;
      miscompares++;
      results;
   end
endmodule : tb
